// ---- hw/dle_pkg.sv ----
/*
 * Shared constants and carrier types for the diagnostic indicator and
 * interrupt encoder. Assumes a single 10 MHz clock and an AHB-Lite master.
 */
package dle_pkg;

    localparam int NCH    = 2;
    localparam int NMOD   = 26;
    localparam int NCHC   = 16;
    localparam int NEV    = NMOD + NCH * NCHC;
    localparam int EVW    = 6;
    localparam int CODE_W = 10;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte offsets.
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CFG_EN   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_EVENT    = 8'h0c;
    localparam logic [7:0] ADDR_ACK      = 8'h10;
    localparam logic [7:0] ADDR_PEND_MOD = 8'h14;
    localparam logic [7:0] ADDR_PEND_CH  = 8'h18;

    // Field positions.
    localparam int CTRL_CFG_BIT   = 0;
    localparam int CTRL_MISM_BIT  = 1;
    localparam int CTRL_IDENT_BIT = 2;
    localparam int CTRL_ACK_LSB   = 4;
    localparam int EVT_CH_LSB     = 12;
    localparam int EVT_SCOPE_BIT  = 15;
    localparam int EVT_IDX_LSB    = 16;
    localparam int EVT_VALID_BIT  = 31;

    // Reset values.
    localparam logic [31:0]         CTRL_RST   = 32'h0000_0000;
    localparam logic [NCH*NCHC-1:0] CFG_EN_RST = 32'hffff_ffff;

    ////////////////////////////////////////////////////////////////////////
    // Timing: one half period of the common blink.
    localparam int CLK_PERIOD_NS  = 100;
    localparam int BLINK_HALF_MS  = 250;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Fault codes, highest index first.
    localparam logic [NMOD-1:0][CODE_W-1:0] MOD_CODE = {
        10'd803, 10'd802, 10'd794, 10'd793, 10'd792, 10'd787, 10'd786,
        10'd785, 10'd283, 10'd260, 10'd259, 10'd256, 10'd76,  10'd75,
        10'd71,  10'd70,  10'd69,  10'd68,  10'd67,  10'd66,  10'd65,
        10'd64,  10'd30,  10'd17,  10'd16,  10'd5};
    localparam logic [NCHC-1:0][CODE_W-1:0] CH_CODE = {
        10'd800, 10'd798, 10'd797, 10'd796, 10'd784, 10'd778, 10'd775,
        10'd774, 10'd773, 10'd771, 10'd770, 10'd769, 10'd768, 10'd265,
        10'd262, 10'd261};
    // Channel conditions that configuration may switch off.
    localparam logic [NCHC-1:0] CH_CFGABLE = 16'h1307;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [NCH*NCHC-1:0] ch;
        logic [NMOD-1:0]     mod;
    } dle_cond_t;

    typedef struct packed {
        logic           supply;
        logic           module_indicator_a;
        logic [NCH-1:0] stat;
        logic [NCH-1:0] fault;
    } dle_led_t;

endpackage

// ---- hw/dle_module_indicator_a_led_irq.sv ----
/*
 * Indicator drive and diagnostic event encoder with an AHB-Lite register
 * slave. Supplies, process signals and condition levels arrive from other
 * domains and are synchronised here; hready is the slave's own hreadyout.
 */
//
// Notes on behaviour
// - Supply indicator follows load supply presence.
// - Module_indicator_a indicator off without backplane supply.
// - Module_indicator_a indicator flashes while unconfigured.
// - Module_indicator_a lit when configured and no diagnostics.
// - Module_indicator_a flashes when configured with module diagnostics.
// - No channel diagnostic: status follows process.
// - Diagnostic and process 0: status off, fault on.
// - Awaiting acknowledgment: status and fault alternate.
// - Address mismatch: status off, module_indicator_a flashes, faults on.
// - Identification: status and module_indicator_a flash, faults off.
// - One event per condition, tagged module or channel.
// - Module codes 5, 16, 17, 30, 64.
// - Safety parameter codes 65 to 71, 75, 76.
// - Internal fault codes 256, 259, 260.
// - Configurable channel output codes 261, 262, 265.
// - Firmware inconsistency code 283.
// - Discrepancy codes 768 to 771.
// - Input fault codes 773, 774, 775, 778, 784.
// - Module codes 785, 786, 787, 792 to 794.
// - Channel codes 796, 797, 798, 800.
// - Supply monitor codes 802, 803.
`timescale 1ns/1ns
module dle_module_indicator_a_led_irq
    import dle_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_HALF_CYC
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Supplies and process signals, asynchronous.
    input  wire logic        load_supply_ok,
    input  wire logic        bus_supply_ok,
    input  wire logic [NCH-1:0] proc_sig,
    // Diagnostic condition levels, asynchronous.
    input  dle_cond_t        cond_in,
    // Indicators.
    output dle_led_t         leds
);

    localparam int SYNC_W = NMOD + NCH * NCHC + NCH + 2;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers.
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    dle_cond_t         cond_s;
    logic [NCH-1:0]    proc_s;
    logic              load_s;
    logic              bus_s;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {cond_in, proc_sig, load_supply_ok, bus_supply_ok};
            sync2_r <= sync1_r;
        end
    end

    assign {cond_s, proc_s, load_s, bus_s} = sync2_r;

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [31:0]         ctrl_r;
    logic [NCH*NCHC-1:0] cfg_en_r;
    logic [NEV-1:0]      pend_r;
    logic [NEV-1:0]      pend_nxt;
    logic [NEV-1:0]      lvl_q_r;
    logic [NEV-1:0]      lvl;
    logic [NEV-1:0]      en;
    logic [NEV-1:0]      rise;

    wire params_cfg = ctrl_r[CTRL_CFG_BIT];
    wire addr_mism  = ctrl_r[CTRL_MISM_BIT];
    wire ident_on   = ctrl_r[CTRL_IDENT_BIT];
    wire [NCH-1:0] ack_wait = ctrl_r[CTRL_ACK_LSB +: NCH];

    ////////////////////////////////////////////////////////////////////////
    // Event detection, one entry per condition.
    assign lvl = {cond_s.ch, cond_s.mod};

    genvar gi;
    generate
        for (gi = 0; gi < NEV; gi++) begin : g_ev
            if (gi < NMOD) begin : g_mod
                assign en[gi] = 1'b1;
            end else begin : g_ch
                assign en[gi] = cfg_en_r[gi - NMOD]
                              | ~CH_CFGABLE[(gi - NMOD) % NCHC];
            end
            assign rise[gi] = lvl[gi] & ~lvl_q_r[gi] & en[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Fixed priority by index; the lowest pending entry is presented.
    function automatic logic [EVW:0] first_pend(input logic [NEV-1:0] p);
        logic [EVW:0] r;
        r = '0;
        for (int i = NEV - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = {1'b1, i[EVW-1:0]};
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] ev_word(input logic [EVW:0] f);
        logic [31:0]     w;
        logic [EVW-1:0]  ix;
        logic [EVW-1:0]  cx;
        w  = '0;
        ix = f[EVW-1:0];
        cx = '0;
        w[EVT_VALID_BIT] = f[EVW];
        w[EVT_IDX_LSB +: EVW] = ix;
        if (ix < EVW'(NMOD)) begin
            w[CODE_W-1:0] = MOD_CODE[ix];
        end else begin
            cx = ix - EVW'(NMOD);
            w[CODE_W-1:0] = CH_CODE[cx % EVW'(NCHC)];
            w[EVT_SCOPE_BIT] = 1'b1;
            w[EVT_CH_LSB +: 3] = 3'(cx / EVW'(NCHC));
        end
        return w;
    endfunction

    wire [EVW:0] first  = first_pend(pend_r);
    wire [31:0]  ev_reg = ev_word(first);

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite address and data phases; zero wait states, always OKAY.
    logic        dwr_r;
    logic [7:0]  daddr_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_mux;

    wire addr_ok = hsel & htrans[1] & hready;
    wire [7:0] a = haddr[7:0];
    wire [31:0] status_w = {24'h0, leds.fault[0], leds.stat[0],
                            leds.module_indicator_a, leds.supply, 2'h0, load_s, bus_s};

    assign rd_mux = (a == ADDR_CTRL)     ? ctrl_r :
                    (a == ADDR_CFG_EN)   ? cfg_en_r :
                    (a == ADDR_STATUS)   ? status_w :
                    (a == ADDR_EVENT)    ? ev_reg :
                    (a == ADDR_PEND_MOD) ? 32'(pend_r[NMOD-1:0]) :
                    (a == ADDR_PEND_CH)  ? 32'(pend_r[NEV-1:NMOD]) :
                                           32'h0000_0000;

    wire wr_ctrl = dwr_r & (daddr_r == ADDR_CTRL);
    wire wr_cfg  = dwr_r & (daddr_r == ADDR_CFG_EN);
    wire wr_ack  = dwr_r & (daddr_r == ADDR_ACK);

    assign hrdata    = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dwr_r   <= 1'b0;
            daddr_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end else begin
            dwr_r   <= addr_ok & hwrite;
            daddr_r <= a;
            rdata_r <= (addr_ok & ~hwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pending flags; a new event in the clearing cycle survives.
    always_comb begin
        pend_nxt = pend_r;
        if (wr_ack && (hwdata[EVW-1:0] < EVW'(NEV))) begin
            pend_nxt[hwdata[EVW-1:0]] = 1'b0;
        end
        pend_nxt = pend_nxt | rise;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_r   <= CTRL_RST;
            cfg_en_r <= CFG_EN_RST;
            pend_r   <= '0;
            lvl_q_r  <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= hwdata;
            end
            if (wr_cfg) begin
                cfg_en_r <= hwdata[NCH*NCHC-1:0];
            end
            pend_r  <= pend_nxt;
            lvl_q_r <= lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Common blink timebase drives every flashing pattern; the acknowledge-wait fault uses its inverse.
    logic [31:0] blink_cnt_r;
    logic        blink_r;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r >= 32'(BLINK_CYC - 1)) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_r     <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator decode.
    logic [NCH-1:0] ch_module_indicator_a;
    logic [NCH-1:0] stat_nxt;
    logic [NCH-1:0] fault_nxt;
    logic           module_indicator_a_nxt;
    wire            mod_module_indicator_a = |cond_s.mod;

    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch_led
            wire [NCHC-1:0] lv = lvl[NMOD + gi*NCHC +: NCHC];
            wire [NCHC-1:0] ev = en[NMOD + gi*NCHC +: NCHC];
            assign ch_module_indicator_a[gi] = |(lv & ev);
            // Process 1 with a diagnostic keeps status and lights fault.
            assign stat_nxt[gi] =
                addr_mism    ? 1'b0 :
                ident_on     ? blink_r :
                ack_wait[gi] ? blink_r :
                ch_module_indicator_a[gi]  ? proc_s[gi] :
                               proc_s[gi];
            assign fault_nxt[gi] =
                addr_mism    ? 1'b1 :
                ident_on     ? 1'b0 :
                ack_wait[gi] ? ~blink_r :
                ch_module_indicator_a[gi]  ? 1'b1 :
                               1'b0;
        end
    endgenerate

    assign module_indicator_a_nxt = !bus_s                 ? 1'b0 :
                      (addr_mism | ident_on) ? blink_r :
                      !params_cfg            ? blink_r :
                      mod_module_indicator_a               ? blink_r :
                                               1'b1;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            leds <= '0;
        end else begin
            leds.supply <= load_s;
            leds.module_indicator_a   <= module_indicator_a_nxt;
            leds.stat   <= stat_nxt;
            leds.fault  <= fault_nxt;
        end
    end

endmodule

// ---- bench/dle_module_indicator_a_led_irq_properties.sv ----
/* Checker for the indicator drive and event encoder, bound to its top module.
   Assumes three edges from an input pin to an indicator and one-cycle bus answers. */
`timescale 1ns/1ns
module dle_module_indicator_a_led_irq_chk
    import dle_pkg::*;
#(
    parameter int BLINK_CYC = 4
) (
    // Clock, reset and bus.
    input wire logic           ref_clk,
    input wire logic           rstn,
    input wire logic           hsel,
    input wire logic [31:0]    haddr,
    input wire logic [1:0]     htrans,
    input wire logic           hwrite,
    input wire logic           hready,
    input wire logic [31:0]    hwdata,
    input wire logic [31:0]    hrdata,
    // Field side.
    input wire logic           load_supply_ok,
    input wire logic           bus_supply_ok,
    input wire logic [NCH-1:0] proc_sig,
    input wire dle_cond_t      cond_in,
    input wire dle_led_t       leds
);
    // Histories are not reset; the settle counter hides their stale bits.
    logic [2:0] up_r;
    logic [3:0] ls_h, bs_h, p0_h, c0_h, d0_h;
    logic       wc_r, re_r;
    logic [5:0] ctrl_r;
    wire        take = hsel && htrans[1] && hready;
    wire        ok   = up_r == 3'h7;
    always_ff @(posedge ref_clk) begin
        ls_h   <= {ls_h[2:0], load_supply_ok};
        bs_h   <= {bs_h[2:0], bus_supply_ok};
        p0_h   <= {p0_h[2:0], proc_sig[0]};
        c0_h   <= {c0_h[2:0], |cond_in.ch[15:0]};
        d0_h   <= {d0_h[2:0], cond_in.ch[3]};
        up_r   <= rstn ? up_r + {2'h0, !ok} : 3'h0;
        wc_r   <= rstn && take && hwrite && haddr[7:0] == ADDR_CTRL;
        re_r   <= rstn && take && !hwrite && haddr[7:0] == ADDR_EVENT;
        ctrl_r <= !rstn ? 6'h0 : wc_r ? hwdata[5:0] : ctrl_r;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_supply_follow: assert property (
        ok && ls_h[3:1] inside {3'h0, 3'h7} |-> leds.supply == ls_h[2])
        else $error("supply indicator does not follow load supply");
    a_module_indicator_a_dark: assert property (
        ok && bs_h[3:1] == 3'h0 |-> !leds.module_indicator_a) else $error("module_indicator_a lit without bus supply");
    a_event_scope: assert property (
        re_r && hrdata[31] |-> hrdata[15] == (hrdata[21:16] >= NMOD) && (!hrdata[15]
            || hrdata[14:12] == 3'((32'(hrdata[21:16]) - NMOD) / 16)))
        else $error("event scope or channel wrong");
    a_addr_mismatch: assert property (
        ok && ctrl_r[1] && $past(ctrl_r[1]) |-> leds.stat == 2'h0 && leds.fault == 2'h3)
        else $error("mismatch pattern wrong");
    a_ident_flash: assert property (
        ok && bs_h[3:1] == 3'h7 && ctrl_r[2:1] == 2'h2 && $past(ctrl_r[2:1]) == 2'h2
            |-> leds.fault == 2'h0 && leds.stat == {2{leds.module_indicator_a}})
        else $error("identification pattern wrong");
    a_ack_alternate: assert property (
        ok && ctrl_r[4] && $past(ctrl_r[4]) && ctrl_r[2:1] == 2'h0
            && $past(ctrl_r[2:1]) == 2'h0 |-> leds.stat[0] != leds.fault[0])
        else $error("acknowledge wait not alternating");
    a_chan_quiet: assert property (
        ok && ctrl_r[4:1] == 4'h0 && $past(ctrl_r[4:1]) == 4'h0 && c0_h[3:1] == 3'h0
            && p0_h[3:1] inside {3'h0, 3'h7} |-> !leds.fault[0] && leds.stat[0] == p0_h[2])
        else $error("quiet channel indicators wrong");
    a_chan_fault: assert property (
        ok && ctrl_r[4:1] == 4'h0 && $past(ctrl_r[4:1]) == 4'h0 && d0_h[3:1] == 3'h7
            && p0_h[3:1] == 3'h0 |-> leds.fault[0] && !leds.stat[0])
        else $error("channel fault indicators wrong");
    c_event_read: cover property (re_r && hrdata[31]);
    c_mismatch: cover property (ok && ctrl_r[1]);
    c_chan_fault: cover property (ok && d0_h[3:1] == 3'h7);
endmodule

bind dle_module_indicator_a_led_irq dle_module_indicator_a_led_irq_chk #(.BLINK_CYC(BLINK_CYC)) dle_module_indicator_a_led_irq_chk_i (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .load_supply_ok(load_supply_ok), .bus_supply_ok(bus_supply_ok),
    .proc_sig(proc_sig), .cond_in(cond_in), .leds(leds));

// ---- bench/dle_ctrl_model.sv ----
/* Fail-safe controller model: an AHB-Lite master reading diagnostics.
   Assumes one slave whose hreadyout is the bus hready. */
`timescale 1ns/1ns
module dle_ctrl_model (
    // Clock and slave answer.
    input  wire logic        ref_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Master request.
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end
    // Decisions rest on bus reads only, never on indicator levels.
    // A stale write word is inverted so that no leftover value can pass for data.
    task automatic req(input logic [7:0] a, input logic w);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hwdata <= ~hwdata;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req(a, 1'b1);
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        req(a, 1'b0);
        do @(posedge ref_clk); while (hready !== 1'b1);
        d = hrdata;
    endtask
endmodule

// ---- bench/dle_module_indicator_a_led_irq_bench.sv ----
/* Self-checking bench for the indicator drive and event encoder.
   Assumes the controller model as bus master and a shortened blink of 4 cycles. */
`timescale 1ns/1ns
module dle_module_indicator_a_led_irq_bench
    import dle_pkg::*;
;
    localparam int BLK = 4;
    logic           ref_clk, rstn, load_supply_ok, bus_supply_ok;
    logic           hsel, hwrite, hreadyout, hresp;
    logic [NCH-1:0] proc_sig;
    logic [1:0]     htrans;
    logic [2:0]     hsize;
    logic [31:0]    haddr, hwdata, hrdata, rdv, ex;
    dle_cond_t      cond_in;
    dle_led_t       leds;
    int             n_errors = 0;
    int             check_count = 0;
    int             c, k;
    int mc[26] = '{5, 16, 17, 30, 64, 65, 66, 67, 68, 69, 70, 71, 75, 76, 256, 259, 260,
                   283, 785, 786, 787, 792, 793, 794, 802, 803};
    int cc[16] = '{261, 262, 265, 768, 769, 770, 771, 773, 774, 775, 778, 784,
                   796, 797, 798, 800};
    dle_module_indicator_a_led_irq #(.BLINK_CYC(BLK)) dle_module_indicator_a_led_irq_i (
        .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .load_supply_ok(load_supply_ok), .bus_supply_ok(bus_supply_ok),
        .proc_sig(proc_sig), .cond_in(cond_in), .leds(leds));
    dle_ctrl_model dle_ctrl_model_i (
        .ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e, m);
        dle_ctrl_model_i.rd(a, rdv);
        chk(nm, e, rdv & m);
    endtask
    function automatic logic [31:0] sf();
        return {28'h0, leds.stat, leds.fault};
    endfunction
    task conclude;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // The run needs about 1100 cycles; the margin covers a slow bus answer.
    initial begin
        cyc(4000);
        n_errors++;
        conclude();
    end
    initial begin
        rstn = 1'b0;
        load_supply_ok = 1'b1;
        bus_supply_ok = 1'b1;
        proc_sig = 2'h0;
        cond_in = '0;
        cyc(10);
        rstn <= 1'b1;
        cyc(1);
        rdc("ctrl", ADDR_CTRL, 32'h0, 32'hffff_ffff);
        rdc("cfg_en", ADDR_CFG_EN, 32'hffff_ffff, 32'hffff_ffff);
        rdc("unmapped", 8'h1c, 32'h0, 32'hffff_ffff);
        rdv[0] = leds.module_indicator_a;
        cyc(BLK);
        chk("module_indicator_a_unconf", {31'h0, ~rdv[0]}, {31'h0, leds.module_indicator_a});
        load_supply_ok <= 1'b0;
        cyc(5);
        chk("supply_off", 32'h0, {31'h0, leds.supply});
        load_supply_ok <= 1'b1;
        bus_supply_ok <= 1'b0;
        cyc(5);
        chk("supply_on", 32'h1, {31'h0, leds.supply});
        repeat (2) begin
            chk("module_indicator_a_dark", 32'h0, {31'h0, leds.module_indicator_a});
            cyc(BLK);
        end
        bus_supply_ok <= 1'b1;
        proc_sig <= 2'h2;
        dle_ctrl_model_i.wr(ADDR_CTRL, 32'h1);
        cyc(5);
        repeat (2) begin
            chk("module_indicator_a_lit", 32'h1, {31'h0, leds.module_indicator_a});
            chk("chan_quiet", 32'h8, sf());
            cyc(BLK);
        end
        rdc("status", ADDR_STATUS, 32'h0000_0033, 32'hffff_ffff);
        for (int i = 0; i < NEV; i++) begin
            if (i < NMOD) cond_in.mod[i] <= 1'b1;
            else cond_in.ch[i-NMOD] <= 1'b1;
            cyc(5);
            ex = 32'h8000_0000 | (32'(i) << 16);
            if (i < NMOD) begin
                rdc("mod_event", ADDR_EVENT, ex | 32'(mc[i]), 32'h803f_83ff);
                rdv[0] = leds.module_indicator_a;
                cyc(BLK);
                chk("module_indicator_a_flash", {31'h0, ~rdv[0]}, {31'h0, leds.module_indicator_a});
            end else begin
                c = (i - NMOD) / 16;
                k = (i - NMOD) % 16;
                ex = ex | 32'h8000 | 32'(c << 12) | 32'(cc[k]);
                rdc("ch_event", ADDR_EVENT, ex, 32'h803f_f3ff);
                chk("chan_fault", 32'h8 | 32'(1 << c), sf());
            end
            if (i < NMOD) rdc("pend_mod", ADDR_PEND_MOD, 32'(1) << i, 32'hffff_ffff);
            else rdc("pend_ch", ADDR_PEND_CH, 32'(1) << (i - NMOD), 32'hffff_ffff);
            dle_ctrl_model_i.wr(ADDR_ACK, 32'(i));
            cond_in <= '0;
            cyc(4);
        end
        rdc("event_idle", ADDR_EVENT, 32'h0, 32'h8000_0000);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
        dle_ctrl_model_i.wr(ADDR_CFG_EN, 32'h0);
        cond_in.ch[0] <= 1'b1;
        cyc(5);
        rdc("cfg_masked", ADDR_EVENT, 32'h0, 32'h8000_0000);
        chk("cfg_quiet", 32'h8, sf());
        cond_in.ch[3] <= 1'b1;
        cyc(5);
        rdc("cfg_fixed", ADDR_EVENT, 32'h801d_8300, 32'h803f_f3ff);
        dle_ctrl_model_i.wr(ADDR_CTRL, 32'h3);
        cyc(4);
        chk("mismatch", 32'h3, sf());
        cond_in <= '0;
        dle_ctrl_model_i.wr(ADDR_CTRL, 32'h5);
        cyc(4);
        rdv[3:0] = sf();
        cyc(BLK);
        chk("ident", {28'h0, ~rdv[3:2], 2'h0}, sf());
        chk("ident_sync", 32'h0, {31'h0, ^rdv[3:2]});
        dle_ctrl_model_i.wr(ADDR_CTRL, 32'h11);
        cyc(4);
        rdv[3:0] = sf();
        cyc(BLK);
        chk("ack_alt", 32'h1, {31'h0, rdv[2] ^ rdv[0]});
        chk("ack_flip", {31'h0, ~rdv[2]}, {31'h0, leds.stat[0]});
        conclude();
    end
endmodule
